// ===== hw/disk_ctrl_host_io_port.sv
`timescale 1ns/10ps
`default_nettype none
// Operation
// - respond only to select code 33 or 73
// - code match gates instruction decode, except mask-out and acknowledge
// - busy and done outputs only while addressed
// - data-out-C loads unit, head, sector, count
// - data-in-A drives status word onto bus
// - data-out-A loads cylinder and command bits
// - command code 10 means seek
// - seek starts on pulse, not load
// - mask-out bit 7 disables interrupts
// - seek completion raises interrupt when enabled
// - acknowledge returns code with request and chain
// - data-out-A word clears pending interrupt
// - command code 01 means write
// - data-out-B loads memory address register
// - adapter select high picks controller A
// - 24-bit two-channel mux, rest direct
// - instructions accepted in any order
// - data-in-C returns unit word contents
// - command decodes to one low line
// - top five bits clear error, done, seek
module disk_ctrl_host_io_port
    import disk_io_pkg::*;
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    // processor i/o bus
    input  wire logic [5:0]            devSel,
    input  wire logic                  dataOutAInstr,
    input  wire logic                  dataOutBInstr,
    input  wire logic                  dataOutCInstr,
    input  wire logic                  dataInAInstr,
    input  wire logic                  dataInCInstr,
    input  wire logic                  ioPulseFunction,
    input  wire logic                  busStartFunction,
    input  wire logic                  maskOutInstr,
    input  wire logic                  interruptAcknowledgeInstr,
    input  wire logic                  irqPriorityChainIn,
    input  wire logic [15:0]           busDataIn,
    output logic [15:0]                busDataOut,
    output logic                       busDataOe,
    output logic                       selectedBusyOut,
    output logic                       selectedDoneOut,
    output logic                       interruptRequestLine,
    // timing section
    input  wire logic [SEEK_FLAGS-1:0] seekCompleteEvent,
    input  wire logic                  transferDoneEvent,
    input  wire logic                  errorEvent,
    input  wire logic [UNITS-1:0]      driveReadyFlag,
    output logic                       seekStart,
    output logic                       transferStart,
    output logic [3:0]                 cmdLineN,
    output logic [15:0]                unitWord,
    output logic [CYL_W-1:0]           cylinder,
    output logic [15:0]                memAddr,
    // adapter
    input  wire logic                  adapterSelA,
    input  wire logic [MUX_W-1:0]      adapterChanA,
    input  wire logic [MUX_W-1:0]      adapterChanB,
    input  wire logic [DIRECT_W-1:0]   adapterDirectIn,
    output logic [MUX_W-1:0]           adapterMuxOut,
    output logic [DIRECT_W-1:0]        adapterDirectOut
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [PIN_W-1:0] pinS1;
    logic [PIN_W-1:0] pinS2;
    logic [PIN_W-1:0] pinS3;
    logic [PIN_W-1:0] pinStable;
    logic [PIN_W-1:0] pinPrev;
    logic [PIN_W-1:0] next_pinStable;
    wire  [PIN_W-1:0] pinRaw = {irqPriorityChainIn, interruptAcknowledgeInstr, maskOutInstr,
                                busStartFunction, ioPulseFunction, dataInCInstr, dataInAInstr,
                                dataOutCInstr, dataOutBInstr, dataOutAInstr, devSel, busDataIn};

    // updates once stages two and three agree; pinS1 feeds pinS2 only
    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi++) begin : g_pin
            assign next_pinStable[gi] = (pinS2[gi] == pinS3[gi]) ? pinS3[gi] : pinStable[gi];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pinS1     <= '0;
            pinS2     <= '0;
            pinS3     <= '0;
            pinStable <= '0;
            pinPrev   <= '0;
        end else begin
            pinS1     <= pinRaw;
            pinS2     <= pinS1;
            pinS3     <= pinS2;
            pinStable <= next_pinStable;
            pinPrev   <= pinStable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // instruction decode
    logic             ctrlSecondary;
    logic [1:0]       cmdMode;
    logic             busy;
    logic             done;
    logic             errFlag;
    logic [SEEK_FLAGS-1:0] seekDone;
    logic             irqDisabled;

    wire [PIN_W-1:0]  rise          = pinStable & ~pinPrev;
    wire [15:0]       data          = pinStable[P_DATA +: 16];
    wire [5:0]        ownCode       = ctrlSecondary ? DEV_CODE_SEC : DEV_CODE_PRI;
    wire              ctrlAddressed = (pinStable[P_SEL +: DEV_CODE_W] == ownCode);
    // instructions act in any order
    wire              doAGo   = rise[P_DOA]  & ctrlAddressed;
    wire              doBGo   = rise[P_DOB]  & ctrlAddressed;
    wire              doCGo   = rise[P_DOC]  & ctrlAddressed;
    wire              iopGo   = rise[P_IOP]  & ctrlAddressed;
    wire              strtGo  = rise[P_BUS_START_FUNCTION] & ctrlAddressed;
    // mask-out is broadcast
    wire              maskGo  = rise[P_MSK];
    wire              inAOn   = pinStable[P_DIA] & ctrlAddressed;
    wire              inCOn   = pinStable[P_DIC] & ctrlAddressed;

    wire              pendingIrqInternal = (|seekDone) | done;
    wire              ackOn   = pinStable[P_IACK] & pendingIrqInternal
                                & pinStable[P_PRIO];

    // pulse and load may coincide; seek sees the new command
    wire [1:0]        cmdNow  = doAGo ? data[B_CMD +: 2] : cmdMode;
    wire              seekGo  = iopGo & (cmdNow == CMD_SEEK);

    wire              clrErr  = doAGo & data[B_CLR_ERR];
    wire              clrDone = doAGo & data[B_CLR_DONE];
    wire [SEEK_FLAGS-1:0] clrSeek = {SEEK_FLAGS{doAGo}} & data[B_CLR_SEEK +: SEEK_FLAGS];

    wire [3:0]        next_cmdLineN = ~(4'h1 << cmdMode);

    ////////////////////////////////////////////////////////////////////////////
    // status word
    logic [15:0] statusWord;
    wire         readySel = driveReadyFlag[unitWord[F_UNIT +: 2]];

    always_comb begin
        statusWord                            = '0;
        statusWord[S_DONE]                    = done;
        statusWord[S_BUSY]                    = busy;
        statusWord[S_ERR]                     = errFlag;
        statusWord[S_READY]                   = readySel;
        statusWord[S_SEEK +: SEEK_FLAGS]      = seekDone;
        statusWord[S_IRQ_OFF]                 = irqDisabled;
    end

    // acknowledge outranks data-in
    wire [15:0] next_busDataOut = ackOn ? {10'h000, ownCode}
                                : inCOn ? unitWord
                                : inAOn ? statusWord
                                : 16'h0000;
    wire        next_busDataOe  = ackOn | inCOn | inAOn;

    ////////////////////////////////////////////////////////////////////////////
    // loadable registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            unitWord <= '0;
            cylinder <= '0;
            cmdMode  <= CMD_RECALIBRATE_CMD;
            memAddr  <= '0;
            cmdLineN <= CMD_LINES_IDLE;
        end else begin
            // count stays negative as written
            if (doCGo) unitWord <= data;
            if (doAGo) cylinder <= data[CYL_W-1:0];
            if (doAGo) cmdMode  <= data[B_CMD +: 2];
            if (doBGo) memAddr  <= data;
            cmdLineN <= next_cmdLineN;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flags and interrupt; set wins over clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy        <= 1'b0;
            done        <= 1'b0;
            errFlag     <= 1'b0;
            seekDone    <= '0;
            irqDisabled <= 1'b0;
        end else begin
            busy        <= strtGo | (busy & ~transferDoneEvent);
            done        <= transferDoneEvent | (done & ~clrDone);
            errFlag     <= errorEvent | (errFlag & ~clrErr);
            seekDone    <= seekCompleteEvent | (seekDone & ~clrSeek);
            if (maskGo) irqDisabled <= data[B_MASK];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus-facing outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busDataOut           <= '0;
            busDataOe            <= 1'b0;
            selectedBusyOut      <= 1'b0;
            selectedDoneOut      <= 1'b0;
            interruptRequestLine <= 1'b0;
            seekStart            <= 1'b0;
            transferStart        <= 1'b0;
        end else begin
            busDataOut           <= next_busDataOut;
            busDataOe            <= next_busDataOe;
            selectedBusyOut      <= busy & ctrlAddressed;
            selectedDoneOut      <= done & ctrlAddressed;
            interruptRequestLine <= pendingIrqInternal & ~irqDisabled;
            seekStart            <= seekGo;
            transferStart        <= strtGo;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb slave; one wait state keeps outputs registered
    logic [31:0] rdMux;
    logic        rdHit;
    wire         accessPh = psel & penable & ~pready;
    wire         wrCtrl   = accessPh & pwrite & (paddr == A_CTRL);

    always_comb begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b1;
        if (paddr == A_CTRL) begin
            rdMux[CTRL_SEC] = ctrlSecondary;
        end else if (paddr == A_STATUS) begin
            rdMux[15:0]          = statusWord;
            rdMux[ST_PENDING]    = pendingIrqInternal;
            rdMux[ST_ADDRESSED]  = ctrlAddressed;
        end else if (paddr == A_CMD) begin
            rdMux[CYL_W-1:0]     = cylinder;
            rdMux[CYL_W +: 2]    = cmdMode;
        end else if (paddr == A_MEMADDR) begin
            rdMux[15:0]          = memAddr;
        end else if (paddr == A_UNIT) begin
            rdMux[15:0]          = unitWord;
        end else begin
            rdHit = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready        <= 1'b0;
            prdata        <= '0;
            pslverr       <= 1'b0;
            ctrlSecondary <= 1'b0;
        end else begin
            pready        <= accessPh;
            prdata        <= (accessPh & ~pwrite) ? rdMux : 32'h0000_0000;
            pslverr       <= accessPh & ~rdHit;
            if (wrCtrl) ctrlSecondary <= pwdata[CTRL_SEC];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // adapter multiplexer
    adapter_link_if adLink ();

    assign adLink.selA     = adapterSelA;
    assign adLink.chanA    = adapterChanA;
    assign adLink.chanB    = adapterChanB;
    assign adLink.directIn = adapterDirectIn;
    assign adapterMuxOut    = adLink.muxOut;
    assign adapterDirectOut = adLink.directOut;

    adapter_mux u_mux (
        .clk     (clk),
        .sys_rst (sys_rst),
        .lnk     (adLink.mux)
    );
endmodule : disk_ctrl_host_io_port
`default_nettype wire

// ===== hw/disk_io_pkg.sv
package disk_io_pkg;
    // select codes, octal 33 and 73
    localparam logic [5:0] DEV_CODE_PRI  = 6'h1B;
    localparam logic [5:0] DEV_CODE_SEC  = 6'h3B;
    localparam int         DEV_CODE_W    = 6;
    ////////////////////////////////////////////////////////////////////////////
    // pin vector layout
    localparam int PIN_W    = 32;
    localparam int P_DATA   = 0;
    localparam int P_SEL    = 16;
    localparam int P_DOA    = 22;
    localparam int P_DOB    = 23;
    localparam int P_DOC    = 24;
    localparam int P_DIA    = 25;
    localparam int P_DIC    = 26;
    localparam int P_IOP    = 27;
    localparam int P_BUS_START_FUNCTION   = 28;
    localparam int P_MSK    = 29;
    localparam int P_IACK   = 30;
    localparam int P_PRIO   = 31;
    ////////////////////////////////////////////////////////////////////////////
    // bus data bit n sits at index 15-n
    localparam int B_CMD        = 8;
    localparam int B_MASK       = 8;
    localparam int B_CLR_ERR    = 15;
    localparam int B_CLR_DONE   = 14;
    localparam int B_CLR_SEEK   = 11;
    localparam int CYL_W        = 8;
    localparam int SEEK_FLAGS   = 3;
    localparam int UNITS        = 4;
    // unit word fields
    localparam int F_UNIT       = 14;
    localparam int F_HEAD       = 12;
    localparam int F_SECT       = 8;
    localparam int F_CNT        = 0;
    // status word fields
    localparam int S_DONE       = 15;
    localparam int S_BUSY       = 14;
    localparam int S_ERR        = 13;
    localparam int S_READY      = 12;
    localparam int S_SEEK       = 9;
    localparam int S_IRQ_OFF    = 8;
    // command codes; line index equals code
    localparam logic [1:0] CMD_RECALIBRATE_CMD = 2'h0;
    localparam logic [1:0] CMD_WRITE = 2'h1;
    localparam logic [1:0] CMD_SEEK  = 2'h2;
    localparam logic [1:0] CMD_READ  = 2'h3;
    localparam logic [3:0] CMD_LINES_IDLE = 4'hF;
    ////////////////////////////////////////////////////////////////////////////
    // apb map
    localparam logic [7:0] A_CTRL    = 8'h00;
    localparam logic [7:0] A_STATUS  = 8'h04;
    localparam logic [7:0] A_CMD     = 8'h08;
    localparam logic [7:0] A_MEMADDR = 8'h0C;
    localparam logic [7:0] A_UNIT    = 8'h10;
    localparam int CTRL_SEC      = 0;
    localparam int ST_PENDING    = 16;
    localparam int ST_ADDRESSED  = 17;
    ////////////////////////////////////////////////////////////////////////////
    // adapter multiplexer
    localparam int MUX_W    = 24;
    localparam int DIRECT_W = 8;
endpackage : disk_io_pkg

// ===== hw/adapter_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface adapter_link_if;
    import disk_io_pkg::*;
    logic                selA;
    logic [MUX_W-1:0]    chanA;
    logic [MUX_W-1:0]    chanB;
    logic [MUX_W-1:0]    muxOut;
    logic [DIRECT_W-1:0] directIn;
    logic [DIRECT_W-1:0] directOut;
    modport mux  (input selA, chanA, chanB, directIn, output muxOut, directOut);
    modport user (output selA, chanA, chanB, directIn, input muxOut, directOut);
endinterface : adapter_link_if
`default_nettype wire

// ===== hw/adapter_mux.sv
`timescale 1ns/10ps
`default_nettype none
module adapter_mux
    import disk_io_pkg::*;
(
    // clock and reset
    input  wire logic     clk,
    input  wire logic     sys_rst,
    // adapter lines
    adapter_link_if.mux   lnk
);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lnk.muxOut    <= '0;
            lnk.directOut <= '0;
        end else begin
            lnk.muxOut    <= lnk.selA ? lnk.chanA : lnk.chanB;
            // unswitched lines, retimed only
            lnk.directOut <= lnk.directIn;
        end
    end
endmodule : adapter_mux
`default_nettype wire

// ===== tb/disk_ctrl_host_io_port_checker.sv
`timescale 1ns/10ps
`default_nettype none
module disk_ctrl_host_io_port_checker
    import disk_io_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // processor bus
    input wire logic [5:0]  devSel,
    input wire logic        dataOutAInstr,
    input wire logic        maskOutInstr,
    input wire logic        ioPulseFunction,
    input wire logic        interruptAcknowledgeInstr,
    input wire logic        irqPriorityChainIn,
    input wire logic [15:0] busDataOut,
    input wire logic        busDataOe,
    input wire logic        selectedBusyOut,
    input wire logic        selectedDoneOut,
    input wire logic        interruptRequestLine,
    // timing section
    input wire logic        seekStart,
    input wire logic        transferStart,
    input wire logic [3:0]  cmdLineN
);
    logic       useSec;
    logic [3:0] hitCnt, missCnt, ackCnt, pulseAge, ctlAge;
    wire  [5:0] myCode = useSec ? DEV_CODE_SEC : DEV_CODE_PRI;
    wire        hit    = devSel == myCode;
    wire        ackOn  = interruptAcknowledgeInstr && irqPriorityChainIn && interruptRequestLine;
    function automatic logic [3:0] inc(input logic [3:0] v);
        return (v == 4'hF) ? v : v + 4'h1;
    endfunction : inc
    ////////////////////////////////////////
    // ages give slack for the pin synchroniser
    always_ff @(posedge clk) begin
        useSec   <= (psel && penable && !pready && pwrite && paddr == A_CTRL) ? pwdata[CTRL_SEC] : useSec;
        hitCnt   <= hit ? inc(hitCnt) : 4'h0;
        missCnt  <= hit ? 4'h0 : inc(missCnt);
        ackCnt   <= ackOn ? inc(ackCnt) : 4'h0;
        pulseAge <= $rose(ioPulseFunction) ? 4'h0 : inc(pulseAge);
        ctlAge   <= (dataOutAInstr || maskOutInstr) ? 4'h0 : inc(ctlAge);
        if (sys_rst) begin
            useSec   <= 1'b0;
            pulseAge <= 4'hF;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    a_apb_answer: assert property (s_access |=> s_answer)
        else $error("no apb answer");
    a_unmapped_err: assert property (s_access ##0 paddr > A_UNIT |=> pslverr && prdata == 32'h0)
        else $error("unmapped no error");
    a_busy_gated: assert property (missCnt == 4'hF |-> !selectedBusyOut && !selectedDoneOut)
        else $error("busy shown unaddressed");
    a_start_needs_sel: assert property ((seekStart || transferStart) |-> hitCnt >= 4'h3)
        else $error("start unselected");
    a_seek_on_pulse: assert property (seekStart |-> pulseAge <= 4'h8)
        else $error("seek without pulse");
    a_seek_line: assert property (seekStart |=> cmdLineN == ~(4'h1 << CMD_SEEK))
        else $error("seek line wrong");
    a_cmd_onehot: assert property (!$past(sys_rst) |-> $onehot(~cmdLineN))
        else $error("command lines not one-hot");
    a_irq_holds: assert property (interruptRequestLine && ctlAge >= 4'h8 |=> interruptRequestLine)
        else $error("irq dropped");
    a_ack_code: assert property (ackCnt >= 4'h7 |-> busDataOe && busDataOut == {10'h0, myCode})
        else $error("ack code wrong");
endmodule : disk_ctrl_host_io_port_checker
bind disk_ctrl_host_io_port disk_ctrl_host_io_port_checker i_chk (.*);
`default_nettype wire

// ===== tb/proc_io_model.sv
`timescale 1ns/10ps
`default_nettype none
module proc_io_model (
    // clock
    input  wire logic   clk,
    // processor i/o bus
    output logic [5:0]  devSel,
    output logic [9:0]  stb,
    output logic [15:0] busDataIn
);
    initial {devSel, stb, busDataIn} = '0;
    // select and data lead the strobe
    task automatic start(input logic [5:0] c, input logic [9:0] s, input logic [15:0] d);
        @(posedge clk);
        devSel <= c;
        busDataIn <= d;
        repeat (2) @(posedge clk);
        stb <= s;
    endtask : start
    // released lines show the inverse
    task automatic stop();
        stb <= 10'h000;
        repeat (4) @(posedge clk);
        devSel <= ~devSel;
        busDataIn <= ~busDataIn;
    endtask : stop
endmodule : proc_io_model
`default_nettype wire

// ===== tb/test_disk_ctrl_host_io_port.sv
`timescale 1ns/10ps
`default_nettype none
module test_disk_ctrl_host_io_port;
    import disk_io_pkg::*;
    localparam logic [9:0] DOA = 10'h001, DOB = 10'h002, DOC = 10'h004, DIA = 10'h008, DIC = 10'h010;
    localparam logic [9:0] IOP = 10'h020, STR = 10'h040, MSK = 10'h080, ACK = 10'h100, PRI = 10'h200;
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, busDataOe, adapterSelA, err;
    logic selectedBusyOut, selectedDoneOut, interruptRequestLine, seekStart, transferStart;
    logic dataOutAInstr, dataOutBInstr, dataOutCInstr, dataInAInstr, dataInCInstr, ioPulseFunction;
    logic busStartFunction, maskOutInstr, interruptAcknowledgeInstr, irqPriorityChainIn;
    logic transferDoneEvent, errorEvent, doneM, busyM, errM, maskM;
    logic [7:0]       paddr, cylinder, adapterDirectIn, adapterDirectOut;
    logic [31:0]      pwdata, prdata, rd;
    logic [5:0]       devSel;
    logic [9:0]       stb;
    logic [15:0]      busDataIn, busDataOut, unitWord, memAddr;
    logic [2:0]       seekCompleteEvent, seekM;
    logic [3:0]       driveReadyFlag, cmdLineN, lines;
    logic [MUX_W-1:0] adapterChanA, adapterChanB, adapterMuxOut;
    int fail_count = 0, checked = 0, cyc = 0, seekCnt = 0, xferCnt = 0;
    int seed, n, s0, unitM, cylM, cmdM, memM, code;
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    assign {irqPriorityChainIn, interruptAcknowledgeInstr, maskOutInstr, busStartFunction, ioPulseFunction,
            dataInCInstr, dataInAInstr, dataOutCInstr, dataOutBInstr, dataOutAInstr} = stb;
    disk_ctrl_host_io_port i_dut (.*);
    proc_io_model i_proc (.clk(clk), .devSel(devSel), .stb(stb), .busDataIn(busDataIn));
    ////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        {err, rd} = {pslverr, prdata};
        {psel, penable} <= 2'b00;
        if (n >= 20) fail_count++;
        @(posedge clk);
    endtask : apb
    task automatic op(input logic [5:0] c, input logic [9:0] s, input logic [15:0] d);
        i_proc.start(c, s, d);
        repeat (8) @(posedge clk);
        i_proc.stop();
    endtask : op
    task automatic ev(input logic [2:0] sk, input logic td, input logic er);
        {seekCompleteEvent, transferDoneEvent, errorEvent} <= {sk, td, er};
        @(posedge clk);
        {seekCompleteEvent, transferDoneEvent, errorEvent} <= 5'h00;
        repeat (3) @(posedge clk);
    endtask : ev
    function automatic logic [7:0] stat();
        return {doneM, busyM, errM, driveReadyFlag[unitM >> 14], seekM, maskM};
    endfunction : stat
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    always @(posedge clk) begin
        cyc++;
        if (seekStart === 1'b1) seekCnt++;
        if (transferStart === 1'b1) xferCnt++;
        if (cyc == 6000) begin
            fail_count++;
            conclude();
        end
    end
    ////////////////////////////////////////
    initial begin
        seed = 32'h0cc2;
        sys_rst <= 1'b1;
        {psel, penable, pwrite, paddr, pwdata, adapterSelA, adapterChanA, adapterChanB, adapterDirectIn} <= '0;
        {seekCompleteEvent, transferDoneEvent, errorEvent} <= 5'h00;
        driveReadyFlag <= 4'($random(seed));
        {doneM, busyM, errM, maskM, seekM, unitM, cylM, cmdM, memM} = '0;
        code = DEV_CODE_PRI;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        check("cmdLines", cmdLineN, 4'hE);
        check("irqLine", interruptRequestLine, 1'b0);
        apb(1'b0, 8'h20, 32'h0);
        check("slvErr", {err, rd[30:0]}, {1'b1, 31'h0});
        apb(1'b0, A_STATUS, 32'h0);
        check("status", rd[15:8], stat());
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            unitM = {i[1:0], 6'($random(seed)), 8'(-(i + 1))};
            op(code, DOC, 16'(unitM));
            check("unitWord", unitWord, unitM);
            op(~code, DOC, ~16'(unitM));
            check("foreign", unitWord, unitM);
            i_proc.start(code, DIC, 16'h0);
            repeat (8) @(posedge clk);
            check("unitRead", {busDataOe, busDataOut}, {1'b1, 16'(unitM)});
            i_proc.stop();
            apb(1'b0, A_STATUS, 32'h0);
            check("ready", rd[15:8], stat());
        end
        $display("test unit word done");
        for (int c = 0; c < 4; c++) begin
            s0 = seekCnt;
            cylM = $random(seed) & 255;
            cmdM = c;
            lines = ~(4'h1 << c);
            op(code, DOA, 16'(cmdM * 256 + cylM));
            check("cylinder", cylinder, cylM);
            check("cmdLines", cmdLineN, lines);
            check("noSeek", seekCnt, s0);
        end
        s0 = seekCnt;
        cmdM = CMD_SEEK;
        op(code, DOA | IOP, 16'(cmdM * 256 + cylM));
        check("seekStart", seekCnt, s0 + 1);
        ev(3'h1, 1'b0, 1'b0);
        seekM[0] = 1'b1;
        check("irqLine", interruptRequestLine, 1'b1);
        repeat (20) @(posedge clk);
        check("irqHold", interruptRequestLine, 1'b1);
        i_proc.start(code, DIA, 16'h0);
        repeat (8) @(posedge clk);
        check("stBus", {busDataOe, busDataOut[15:8]}, {1'b1, stat()});
        i_proc.stop();
        for (int k = 0; k < 2; k++) begin
            i_proc.start(6'h00, ACK | (k ? PRI : 10'h000), 16'h0);
            repeat (8) @(posedge clk);
            check("ackDrive", busDataOe, k);
            if (k) check("ackCode", busDataOut, code);
            i_proc.stop();
        end
        cmdM = CMD_WRITE;
        op(code, DOA, 16'h0800 | 16'(cmdM * 256 + cylM));
        seekM = 3'h0;
        check("irqClear", {interruptRequestLine, cmdLineN}, {1'b0, 4'hD});
        op(6'h00, MSK, 16'h0100);
        maskM = 1'b1;
        ev(3'h4, 1'b0, 1'b0);
        seekM[2] = 1'b1;
        check("irqMasked", interruptRequestLine, 1'b0);
        apb(1'b0, A_STATUS, 32'h0);
        check("stMask", rd[16:8], {1'b1, stat()});
        op(6'h00, MSK, 16'h0000);
        maskM = 1'b0;
        check("irqUnmask", interruptRequestLine, 1'b1);
        op(code, DOA, 16'h2000 | 16'(cmdM * 256 + cylM));
        seekM = 3'h0;
        check("irqClear2", interruptRequestLine, 1'b0);
        $display("test seek done");
        s0 = xferCnt;
        memM = $random(seed) & 16'hFFFF;
        i_proc.start(code, DOB | STR, 16'(memM));
        repeat (8) @(posedge clk);
        busyM = 1'b1;
        check("busySel", selectedBusyOut, 1'b1);
        i_proc.stop();
        check("memAddr", memAddr, memM);
        check("xferStart", xferCnt, s0 + 1);
        repeat (8) @(posedge clk);
        check("desel", selectedBusyOut, 1'b0);
        ev(3'h0, 1'b1, 1'b1);
        {busyM, doneM, errM} = 3'b011;
        apb(1'b0, A_STATUS, 32'h0);
        check("stDone", {interruptRequestLine, rd[15:8]}, {1'b1, stat()});
        op(code, DOA, 16'hC000 | 16'(cmdM * 256 + cylM));
        {doneM, errM} = 2'b00;
        apb(1'b0, A_STATUS, 32'h0);
        check("statusClr", {interruptRequestLine, rd[15:8]}, {1'b0, stat()});
        apb(1'b1, A_CTRL, 32'h1);
        unitM = $random(seed) & 16'hFFFF;
        op(DEV_CODE_SEC, DOC, 16'(unitM));
        op(DEV_CODE_PRI, DOC, ~16'(unitM));
        check("second", unitWord, unitM);
        apb(1'b1, A_CTRL, 32'h0);
        apb(1'b0, A_MEMADDR, 32'h0);
        check("memReg", rd[15:0], memM);
        apb(1'b0, A_CMD, 32'h0);
        check("cmdReg", rd[9:0], cmdM * 256 + cylM);
        $display("test transfer done");
        for (int k = 0; k < 16; k++) begin
            adapterSelA <= 1'($random(seed));
            adapterChanA <= MUX_W'($random(seed));
            adapterChanB <= MUX_W'($random(seed));
            adapterDirectIn <= 8'($random(seed));
            repeat (2) @(posedge clk);
            check("muxOut", adapterMuxOut, adapterSelA ? adapterChanA : adapterChanB);
            check("directOut", adapterDirectOut, adapterDirectIn);
        end
        $display("test adapter done");
        conclude();
    end
endmodule : test_disk_ctrl_host_io_port
`default_nettype wire
